//--- src/asis_pkg.sv
// Shared constants and types for the sensor-slave fieldbus link
package asis_pkg;
  // Link field widths
  localparam int ASIS_ADDR_W = 5;
  localparam int ASIS_DATA_W = 4;
  localparam int ASIS_GROUP_W = 4;
  // Address that every slave leaves the factory with
  localparam logic [4:0] ASIS_FACTORY_ADDR = 5'h00;
  // Highest address a master may hand out
  localparam logic [4:0] ASIS_MAX_ADDR = 5'h1f;
  // Port selector: shared line, or one of the two programming ports
  localparam logic [1:0] ASIS_PORT_LINE = 2'h0;
  localparam logic [1:0] ASIS_PORT_PROG_FIRST = 2'h1;
  localparam logic [1:0] ASIS_PORT_PROG_SECOND = 2'h2;
  // Commands carried by a link request
  typedef enum logic {ASIS_CMD_XCHG, ASIS_CMD_ASSIGN} asis_cmd_e;
  // Register offsets of the master's APB slave
  localparam logic [11:0] ASIS_CTRL_OFS = 12'h000;
  localparam logic [11:0] ASIS_STAT_OFS = 12'h004;
  // Control word fields
  localparam int ASIS_CTRL_ADDR_LSB = 0;
  localparam int ASIS_CTRL_NEW_LSB = 8;
  localparam int ASIS_CTRL_PORT_LSB = 16;
  localparam int ASIS_CTRL_CMD_BIT = 20;
  // Status word fields
  localparam int ASIS_STAT_BUSY_BIT = 0;
  localparam int ASIS_STAT_DONE_BIT = 1;
  localparam int ASIS_STAT_NOREPLY_BIT = 2;
  localparam int ASIS_STAT_REFUSED_BIT = 3;
  localparam int ASIS_STAT_DATA_LSB = 8;
  // Reply timeout
  localparam int ASIS_CLK_PERIOD_NS = 4;
  localparam int ASIS_REPLY_TIMEOUT_NS = 64;
  localparam int ASIS_REPLY_TIMEOUT_CYC = ASIS_REPLY_TIMEOUT_NS / ASIS_CLK_PERIOD_NS;
endpackage

//--- src/asis_link_if.sv
// Logic-level fieldbus link between master and sensor slave device
interface asis_link_if (
  input wire logic pclk,
  input wire logic presetn
);
  import asis_pkg::*;
  logic req_valid;
  logic [ASIS_ADDR_W-1:0] req_addr;
  asis_cmd_e req_cmd;
  logic [ASIS_ADDR_W-1:0] req_data;
  logic [1:0] port_sel;
  logic rsp_valid;
  logic [ASIS_DATA_W-1:0] rsp_data;
  modport slave (
    input req_valid,
    input req_addr,
    input req_cmd,
    input req_data,
    input port_sel,
    output rsp_valid,
    output rsp_data
  );
  modport master (
    output req_valid,
    output req_addr,
    output req_cmd,
    output req_data,
    output port_sel,
    input rsp_valid,
    input rsp_data
  );
endinterface

//--- src/asis_slave_dev.sv
// Sensor slave device: one or two bus slaves reporting groups of four inputs
//
// Overview of operation
// - Four-input variant is one slave, one address.
// - Eight-input variant is two independent slaves.
// - Two groups of four inputs, one per slave.
// - No active input replies all-zero user data.
// - First input drives user data bit zero.
// - Inputs two to four drive bits one to three.
// - Frame has address and four data bits; match own.
// - Master hands out distinct addresses up to 31.
// - Factory address zero; master assigns a free one.
// - Assigned address kept non-volatile; any value but zero allowed.
// - Jumper removed: each slave programmed on own port.
// - Jumper fitted: both slaves reachable on shared line.
module asis_slave_dev #(
  parameter int NUM_SLAVES = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic factory_rstn,
  asis_link_if.slave link,
  input wire logic [asis_pkg::ASIS_GROUP_W*NUM_SLAVES-1:0] in_level,
  input wire logic jumper_fitted,
  output logic [asis_pkg::ASIS_ADDR_W*NUM_SLAVES-1:0] slave_addr
);
  import asis_pkg::*;

  localparam int IN_W = ASIS_GROUP_W * NUM_SLAVES;

  typedef struct packed {
    logic [IN_W:0] sync1;
    logic [IN_W:0] sync2;
    logic rsp_valid;
    logic [ASIS_DATA_W-1:0] rsp_data;
  } asis_dev_s;

  asis_dev_s s_r;
  asis_dev_s s_nxt;
  logic [ASIS_ADDR_W-1:0] addr_mem [NUM_SLAVES];
  logic hit_any;
  int hit_idx;

  ////////////////////////////////////////////////////////////////////////////
  // Port decode: which slave may hear the current request
  function automatic logic port_ok(input int idx, input logic jmp, input logic [1:0] ps);
    logic ok;
    ok = 1'b0;
    if (NUM_SLAVES == 1) begin
      ok = 1'b1;
    end else if (jmp) begin
      ok = (ps == ASIS_PORT_LINE);
    end else begin
      ok = (ps == ASIS_PORT_PROG_FIRST && idx == 0) ||
           (ps == ASIS_PORT_PROG_SECOND && idx == 1);
    end
    return ok;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state: sync pins, match address, build reply
  always_comb begin
    s_nxt = s_r;
    hit_any = 1'b0;
    hit_idx = 0;
    // Two-stage sync; only stage two is read by logic
    s_nxt.sync1 = {jumper_fitted, in_level};
    s_nxt.sync2 = s_r.sync1;
    s_nxt.rsp_valid = 1'b0;
    // Lowest slave wins if both still share an address
    for (int i = 0; i < NUM_SLAVES; i++) begin
      if (!hit_any && link.req_valid && port_ok(i, s_r.sync2[IN_W], link.port_sel) &&
          addr_mem[i] == link.req_addr) begin
        hit_any = 1'b1;
        hit_idx = i;
      end
    end
    if (hit_any) begin
      s_nxt.rsp_valid = 1'b1;
      if (link.req_cmd == ASIS_CMD_XCHG) begin
        // Bit n of the group is input n+1; all active bits together
        s_nxt.rsp_data = s_r.sync2[hit_idx*ASIS_GROUP_W +: ASIS_GROUP_W];
      end else begin
        s_nxt.rsp_data = 4'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address store: bus power loss does not clear it, only factory erase
  always_ff @(posedge pclk or negedge factory_rstn) begin
    if (!factory_rstn) begin
      for (int i = 0; i < NUM_SLAVES; i++) begin
        addr_mem[i] <= ASIS_FACTORY_ADDR;
      end
    end else if (hit_any && link.req_cmd == ASIS_CMD_ASSIGN) begin
      addr_mem[hit_idx] <= link.req_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign link.rsp_valid = s_r.rsp_valid;
  assign link.rsp_data = s_r.rsp_data;
  for (genvar g = 0; g < NUM_SLAVES; g++) begin : g_addr
    assign slave_addr[g*ASIS_ADDR_W +: ASIS_ADDR_W] = addr_mem[g];
  end
endmodule

//--- src/asis_bus_master.sv
// Fieldbus master end: APB-programmed command engine driving the link
module asis_bus_master (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  asis_link_if.master link
);
  import asis_pkg::*;

  typedef enum logic {ASIS_ST_IDLE, ASIS_ST_WAIT} asis_mst_e;

  typedef struct packed {
    asis_mst_e state;
    logic req_valid;
    logic [ASIS_ADDR_W-1:0] req_addr;
    asis_cmd_e req_cmd;
    logic [ASIS_ADDR_W-1:0] req_data;
    logic [1:0] port_sel;
    logic [7:0] timer;
    logic done;
    logic noreply;
    logic refused;
    logic [ASIS_DATA_W-1:0] rsp_data;
    logic [31:0] prdata;
  } asis_mst_s;

  asis_mst_s m_r;
  asis_mst_s m_nxt;
  logic wr_ctrl;
  logic mapped;
  logic [31:0] stat_word;
  logic [31:0] ctrl_word;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode and register views
  assign mapped = (paddr == ASIS_CTRL_OFS) || (paddr == ASIS_STAT_OFS);
  assign wr_ctrl = psel && penable && pwrite && (paddr == ASIS_CTRL_OFS);
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[ASIS_STAT_BUSY_BIT] = (m_r.state == ASIS_ST_WAIT);
    stat_word[ASIS_STAT_DONE_BIT] = m_r.done;
    stat_word[ASIS_STAT_NOREPLY_BIT] = m_r.noreply;
    stat_word[ASIS_STAT_REFUSED_BIT] = m_r.refused;
    stat_word[ASIS_STAT_DATA_LSB +: ASIS_DATA_W] = m_r.rsp_data;
    ctrl_word = 32'h0000_0000;
    ctrl_word[ASIS_CTRL_ADDR_LSB +: ASIS_ADDR_W] = m_r.req_addr;
    ctrl_word[ASIS_CTRL_NEW_LSB +: ASIS_ADDR_W] = m_r.req_data;
    ctrl_word[ASIS_CTRL_PORT_LSB +: 2] = m_r.port_sel;
    ctrl_word[ASIS_CTRL_CMD_BIT] = (m_r.req_cmd == ASIS_CMD_ASSIGN);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command engine: one request, then wait for reply or timeout
  always_comb begin
    m_nxt = m_r;
    m_nxt.req_valid = 1'b0;
    // Read data captured in setup so the access phase needs no wait state
    if (psel && !penable && !pwrite) begin
      m_nxt.prdata = (paddr == ASIS_STAT_OFS) ? stat_word :
                     (paddr == ASIS_CTRL_OFS) ? ctrl_word : 32'h0000_0000;
    end
    unique case (m_r.state)
      ASIS_ST_IDLE: begin
        if (wr_ctrl) begin
          if (pwdata[ASIS_CTRL_CMD_BIT] &&
              pwdata[ASIS_CTRL_NEW_LSB +: ASIS_ADDR_W] == ASIS_FACTORY_ADDR) begin
            // Zero is the unassigned address, never handed out
            m_nxt.refused = 1'b1;
          end else begin
            m_nxt.req_valid = 1'b1;
            m_nxt.req_addr = pwdata[ASIS_CTRL_ADDR_LSB +: ASIS_ADDR_W];
            m_nxt.req_data = pwdata[ASIS_CTRL_NEW_LSB +: ASIS_ADDR_W];
            m_nxt.port_sel = pwdata[ASIS_CTRL_PORT_LSB +: 2];
            m_nxt.req_cmd = pwdata[ASIS_CTRL_CMD_BIT] ? ASIS_CMD_ASSIGN : ASIS_CMD_XCHG;
            m_nxt.timer = 8'(ASIS_REPLY_TIMEOUT_CYC);
            m_nxt.done = 1'b0;
            m_nxt.noreply = 1'b0;
            m_nxt.refused = 1'b0;
            m_nxt.state = ASIS_ST_WAIT;
          end
        end
      end
      ASIS_ST_WAIT: begin
        // Commands written while busy are dropped and flagged
        if (wr_ctrl) begin
          m_nxt.refused = 1'b1;
        end
        if (link.rsp_valid) begin
          m_nxt.rsp_data = link.rsp_data;
          m_nxt.done = 1'b1;
          m_nxt.state = ASIS_ST_IDLE;
        end else if (m_r.timer == 8'h00) begin
          m_nxt.noreply = 1'b1;
          m_nxt.done = 1'b1;
          m_nxt.state = ASIS_ST_IDLE;
        end else begin
          m_nxt.timer = m_r.timer - 8'h01;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_r <= '0;
    end else begin
      m_r <= m_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign prdata = m_r.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped; // Unmapped access flagged
  assign link.req_valid = m_r.req_valid;
  assign link.req_addr = m_r.req_addr;
  assign link.req_cmd = m_r.req_cmd;
  assign link.req_data = m_r.req_data;
  assign link.port_sel = m_r.port_sel;
endmodule

//--- dv/asis_link_props.sv
// Concurrent checks on the link between the master end and the sensor slave device
module asis_link_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req_valid,
  input wire logic [asis_pkg::ASIS_ADDR_W-1:0] req_addr,
  input wire asis_pkg::asis_cmd_e req_cmd,
  input wire logic [asis_pkg::ASIS_ADDR_W-1:0] req_data,
  input wire logic [1:0] port_sel,
  input wire logic rsp_valid,
  input wire logic [asis_pkg::ASIS_DATA_W-1:0] rsp_data
);
  import asis_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////
  // Request side: one short pulse, fields held, no zero address assigned, legal port
  property p_req_pulse; req_valid |=> !req_valid [*2]; endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("request not a lone pulse");
  property p_req_hold;
    req_valid |=> $stable(req_addr) && $stable(req_cmd) && $stable(req_data);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request fields moved");
  property p_no_zero_assign; req_valid && req_cmd == ASIS_CMD_ASSIGN |-> req_data != 5'h00;
  endproperty
  a_no_zero_assign: assert property (p_no_zero_assign) else $error("zero address sent");
  property p_port_legal; port_sel != 2'h3; endproperty
  a_port_legal: assert property (p_port_legal) else $error("unknown port selected");
  ////////////////////////////////////////////////////////////////////////////
  // Reply side: only one cycle after a request, and data that stands
  property p_rsp_cause; rsp_valid |-> $past(req_valid); endproperty
  a_rsp_cause: assert property (p_rsp_cause) else $error("reply without request");
  property p_rsp_once; rsp_valid |=> !rsp_valid; endproperty
  a_rsp_once: assert property (p_rsp_once) else $error("reply longer than a cycle");
  property p_ack_zero; rsp_valid && req_cmd == ASIS_CMD_ASSIGN |-> rsp_data == 4'h0;
  endproperty
  a_ack_zero: assert property (p_ack_zero) else $error("assign ack data not zero");
  property p_rsp_stands; !rsp_valid |-> $stable(rsp_data); endproperty
  a_rsp_stands: assert property (p_rsp_stands) else $error("reply data moved");
  c_ack: cover property (rsp_valid && req_cmd == ASIS_CMD_ASSIGN);
endmodule

//--- dv/asi_sensor_slave_inputs_bench.sv
// Self-checking bench: APB-driven master end facing a two-slave sensor device
module asi_sensor_slave_inputs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import asis_pkg::*;
  logic pclk = 0, presetn = 0, factory_rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic jumper_fitted = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [7:0] in_level = '0;
  wire logic [31:0] prdata;
  wire logic pready, pslverr;
  wire logic [9:0] slave_addr;
  int error_cnt = 0, comparisons = 0;
  ////////////////////////////////////////////////////////////////////////////
  // Clock and the two ends joined by the link
  always #2 pclk = ~pclk;
  asis_link_if i_asis_link_if (.pclk(pclk), .presetn(presetn));
  asis_bus_master i_asis_bus_master (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(i_asis_link_if));
  asis_slave_dev #(.NUM_SLAVES(2)) i_asis_slave_dev (.pclk(pclk), .presetn(presetn),
    .factory_rstn(factory_rstn), .link(i_asis_link_if), .in_level(in_level),
    .jumper_fitted(jumper_fitted), .slave_addr(slave_addr));
  asis_link_props i_asis_link_props (.pclk(pclk), .presetn(presetn),
    .req_valid(i_asis_link_if.req_valid), .req_addr(i_asis_link_if.req_addr),
    .req_cmd(i_asis_link_if.req_cmd), .req_data(i_asis_link_if.req_data),
    .port_sel(i_asis_link_if.port_sel), .rsp_valid(i_asis_link_if.rsp_valid),
    .rsp_data(i_asis_link_if.rsp_data));
  ////////////////////////////////////////////////////////////////////////////
  // Compares, one per kind of result
  task automatic chk_data(input logic [3:0] g, input logic [3:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t user data %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t status flag %b expected %b", $time, g, e);
    end
  endtask
  task automatic chk_addr(input logic [9:0] g, input logic [9:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t stored addresses %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t register word %h expected %h", $time, g, e);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // APB transfer; holds the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No wait count assumed; only the watchdog ends a stuck access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Launch one command, then poll until busy drops; the watchdog ends a hang
  task automatic cmd(input logic c, input logic [4:0] t, input logic [4:0] nw,
                     input logic [1:0] p, output logic [31:0] s);
    logic [31:0] r;
    logic e;
    apb(1'b1, ASIS_CTRL_OFS, (32'(c) << ASIS_CTRL_CMD_BIT) | (32'(p) << ASIS_CTRL_PORT_LSB) |
        (32'(nw) << ASIS_CTRL_NEW_LSB) | (32'(t) << ASIS_CTRL_ADDR_LSB), r, e);
    do begin
      apb(1'b0, ASIS_STAT_OFS, 32'h0000_0000, s, e);
    end while (s[ASIS_STAT_BUSY_BIT] !== 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Jumper removed: each input alone, none, and several at once on slave 0
  task automatic sc_inputs;
    logic [31:0] s;
    logic [3:0] e;
    for (int i = 0; i < 6; i++) begin
      e = (i == 0) ? 4'h0 : (i == 5) ? 4'hb : 4'(4'h1 << (i - 1));
      in_level <= {4'hf, e};
      repeat (3) @(posedge pclk);
      cmd(ASIS_CMD_XCHG, 5'h00, 5'h00, ASIS_PORT_PROG_FIRST, s);
      chk_data(s[ASIS_STAT_DATA_LSB +: 4], e);
    end
    cmd(ASIS_CMD_XCHG, 5'h00, 5'h00, ASIS_PORT_PROG_SECOND, s);
    chk_data(s[ASIS_STAT_DATA_LSB +: 4], 4'hf);
  endtask
  // Separate addressing on the programming ports, and a refused zero address
  task automatic sc_assign;
    logic [31:0] s;
    logic [31:0] r;
    logic e;
    cmd(ASIS_CMD_ASSIGN, 5'h00, 5'h05, ASIS_PORT_PROG_FIRST, s);
    chk_addr(slave_addr, {5'h00, 5'h05});
    cmd(ASIS_CMD_ASSIGN, 5'h00, ASIS_MAX_ADDR, ASIS_PORT_PROG_SECOND, s);
    chk_addr(slave_addr, {ASIS_MAX_ADDR, 5'h05});
    cmd(ASIS_CMD_ASSIGN, 5'h05, 5'h00, ASIS_PORT_PROG_FIRST, s);
    chk_bit(s[ASIS_STAT_REFUSED_BIT], 1'b1);
    chk_addr(slave_addr, {ASIS_MAX_ADDR, 5'h05});
    // A refused command must leave the last accepted one in the control word
    apb(1'b0, ASIS_CTRL_OFS, 32'h0000_0000, r, e);
    chk_word(r, (32'(1'b1) << ASIS_CTRL_CMD_BIT) |
             (32'(ASIS_PORT_PROG_SECOND) << ASIS_CTRL_PORT_LSB) |
             (32'(ASIS_MAX_ADDR) << ASIS_CTRL_NEW_LSB));
  endtask
  // Jumper fitted: both slaves on the shared line, strangers get no reply
  task automatic sc_shared;
    logic [31:0] s;
    jumper_fitted <= 1'b1;
    in_level <= 8'h5a;
    repeat (4) @(posedge pclk);
    cmd(ASIS_CMD_XCHG, 5'h05, 5'h00, ASIS_PORT_LINE, s);
    chk_data(s[ASIS_STAT_DATA_LSB +: 4], 4'ha);
    cmd(ASIS_CMD_XCHG, ASIS_MAX_ADDR, 5'h00, ASIS_PORT_LINE, s);
    chk_data(s[ASIS_STAT_DATA_LSB +: 4], 4'h5);
    cmd(ASIS_CMD_XCHG, 5'h07, 5'h00, ASIS_PORT_LINE, s);
    chk_bit(s[ASIS_STAT_NOREPLY_BIT], 1'b1);
    cmd(ASIS_CMD_XCHG, 5'h05, 5'h00, ASIS_PORT_PROG_FIRST, s);
    chk_bit(s[ASIS_STAT_NOREPLY_BIT], 1'b1);
  endtask
  // Bus power loss keeps addresses; only the factory erase clears them
  task automatic sc_persist;
    logic [31:0] r;
    logic e;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk_addr(slave_addr, {ASIS_MAX_ADDR, 5'h05});
    apb(1'b0, 12'h008, 32'h0000_0000, r, e);
    chk_bit(e, 1'b1);
    factory_rstn <= 1'b0;
    @(posedge pclk);
    factory_rstn <= 1'b1;
    @(posedge pclk);
    chk_addr(slave_addr, 10'h000);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Verdict, reached from the main sequence or the watchdog
  task automatic tally_and_finish;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #50000;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    factory_rstn <= 1'b1;
    @(posedge pclk);
    chk_addr(slave_addr, 10'h000);
    sc_inputs();
    sc_assign();
    sc_shared();
    sc_persist();
    tally_and_finish();
  end
endmodule
